// File: hdl/tapp_pkg.sv
// constants and types shared by the two-axis pulse positioner
package tapp_pkg;

  localparam int          CLK_HZ       = 25_000_000;
  localparam int          MS_TIME      = 1;
  localparam int          MS_CYC_DEF   = (CLK_HZ / 1000) * MS_TIME;
  localparam int          NUM_CH       = 2;
  localparam logic [4:0]  STEP_FIRST   = 5'h01;
  localparam logic [4:0]  STEP_LAST    = 5'h14;
  localparam logic [4:0]  STEP_AUTO    = 5'h00;
  localparam logic [16:0] SPEED_MIN    = 17'h00005;
  localparam logic [16:0] SPEED_MAX    = 17'h186a0;
  localparam logic [13:0] DWELL_MAX    = 14'h2710;
  localparam logic [16:0] JOG_LO_DEF   = 17'h003e8;
  localparam logic [16:0] JOG_HI_DEF   = 17'h02710;
  localparam logic [16:0] RAMP_DEF     = 17'h003e8;

  localparam logic [7:0]  CTRL_DECEL   = 8'h00;
  localparam logic [7:0]  CTRL_ESTOP   = 8'h01;
  localparam logic [7:0]  CTRL_ERRRST  = 8'h02;

  localparam logic [1:0]  MODE_END     = 2'h0;
  localparam logic [1:0]  MODE_KEEP    = 2'h1;
  localparam logic [1:0]  MODE_CONT    = 2'h2;

  // step table entry layout
  localparam int          F_ADDR       = 0;
  localparam int          F_SPEED      = 32;
  localparam int          F_DWELL      = 49;
  localparam int          F_NEXT       = 63;
  localparam int          F_ABS        = 68;
  localparam int          F_MODE       = 69;
  localparam int          F_REPEAT     = 71;
  localparam int          ENTRY_W      = 72;

  typedef enum logic [2:0] {
    TAPP_IDLE, TAPP_FETCH, TAPP_LOAD, TAPP_MOVE, TAPP_DWELL, TAPP_JOG
  } tapp_state_t;

endpackage : tapp_pkg

// File: hdl/tapp_step_mem.sv
// step table storage for one channel, registered read
`timescale 1ns/1ps
module tapp_step_mem
  import tapp_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = 21
) (
  input  wire logic             clock,
  input  wire logic             wr_en,
  input  wire logic [4:0]       wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [4:0]       rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en && (int'(wr_idx) < DEPTH)) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= (int'(rd_idx) < DEPTH) ? mem[rd_idx] : '0;
  end

endmodule : tapp_step_mem

// File: hdl/tapp_pulse_gen.sv
// phase accumulator that turns a pps rate into one-cycle pulse ticks
`timescale 1ns/1ps
module tapp_pulse_gen
  import tapp_pkg::*;
#(
  parameter int HZ = CLK_HZ
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic [16:0] speed,
  output logic             tick
);

  localparam logic [25:0] HZ_W = 26'(HZ);

  logic [25:0] acc_r;
  logic [25:0] acc_nxt;
  logic        tick_nxt;
  logic [25:0] sum;

  always_comb begin
    sum      = acc_r + {9'h000, speed};
    acc_nxt  = sum;
    tick_nxt = 1'b0;
    if (!run) begin
      acc_nxt = '0;
    end else if (sum >= HZ_W) begin
      acc_nxt  = sum - HZ_W;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
      tick  <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule : tapp_pulse_gen

// File: hdl/tapp_positioner.sv
// two-channel pulse-train positioner: step sequencer, jog and control
`timescale 1ns/1ps
//
// Behaviour
// - next step zero advances to following step
// - absolute move direction from start versus goal
// - absolute positions referenced to preset origin
// - incremental move direction from amount sign
// - step mode end, keep or continuous
// - single or repeat method per step
// - signed 32-bit positioning address in pulses
// - step speed 5 to 100000 pps
// - run-time table updates are honoured
// - dwell in ms before next step
// - indirect start on rising condition edge
// - jog runs while condition high
// - jog speed change live, direction ignored
// - bad channel raises error, no execution
// - control codes decel, emergency, error reset
// - emergency immediate, decel stop ramps down
// - error reset clears error and prohibition
// - limit or estop while busy stops and prohibits start (jog still allowed)
// - step numbers 1 to 20
module tapp_positioner
  import tapp_pkg::*;
#(
  parameter int          MS_CYCLES = MS_CYC_DEF,
  parameter logic [16:0] JOG_LO    = JOG_LO_DEF,
  parameter logic [16:0] JOG_HI    = JOG_HI_DEF,
  parameter logic [16:0] RAMP_PPS  = RAMP_DEF
) (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   tbl_wr_en,
  input  wire logic [7:0]             tbl_wr_ch,
  input  wire logic [4:0]             tbl_wr_step,
  input  wire logic [31:0]            tbl_wr_addr,
  input  wire logic [16:0]            tbl_wr_speed,
  input  wire logic [13:0]            tbl_wr_dwell,
  input  wire logic [4:0]             tbl_wr_next,
  input  wire logic                   tbl_wr_abs,
  input  wire logic [1:0]             tbl_wr_mode,
  input  wire logic                   tbl_wr_repeat,
  input  wire logic                   start_cond,
  input  wire logic [7:0]             start_ch,
  input  wire logic [7:0]             start_step,
  input  wire logic                   jog_cond,
  input  wire logic [7:0]             jog_ch,
  input  wire logic                   first_numeric_operand,
  input  wire logic                   second_numeric_operand,
  input  wire logic                   ctrl_cond,
  input  wire logic [7:0]             ctrl_ch,
  input  wire logic [7:0]             ctrl_code,
  input  wire logic                   preset_cond,
  input  wire logic [7:0]             preset_ch,
  input  wire logic [31:0]            preset_value_operand,
  input  wire logic [NUM_CH-1:0]      limit_lo_pin,
  input  wire logic [NUM_CH-1:0]      limit_hi_pin,
  input  wire logic [NUM_CH-1:0]      estop_pin,
  output logic      [NUM_CH-1:0]      pulse_out,
  output logic      [NUM_CH-1:0]      dir_rev_out,
  output logic      [NUM_CH-1:0]      busy,
  output logic      [NUM_CH-1:0]      error_latched,
  output logic      [NUM_CH-1:0]      output_prohibit,
  output logic      [NUM_CH-1:0][4:0] step_now,
  output logic      [NUM_CH-1:0][31:0] cur_pos,
  output logic                        instruction_error_flag
);

  localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

  // command edges and operand checks
  logic start_d_r, jog_d_r, ctrl_d_r, preset_d_r;
  logic start_rise, jog_rise, ctrl_rise, preset_rise;
  logic start_bad, jog_bad, ctrl_bad, preset_bad;
  logic ierr_nxt, ierr_r;

  assign start_rise  = start_cond && !start_d_r;
  assign jog_rise    = jog_cond && !jog_d_r;
  assign ctrl_rise   = ctrl_cond && !ctrl_d_r;
  assign preset_rise = preset_cond && !preset_d_r;
  assign start_bad   = (start_ch >= 8'(NUM_CH)) ||
                       (start_step < {3'h0, STEP_FIRST}) ||
                       (start_step > {3'h0, STEP_LAST});
  assign jog_bad     = jog_ch >= 8'(NUM_CH);
  assign ctrl_bad    = (ctrl_ch >= 8'(NUM_CH)) ||
                       (ctrl_code > CTRL_ERRRST);
  assign preset_bad  = preset_ch >= 8'(NUM_CH);

  always_comb begin
    ierr_nxt = (start_rise && start_bad) || (jog_rise && jog_bad) ||
               (ctrl_rise && ctrl_bad) || (preset_rise && preset_bad);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      start_d_r  <= 1'b0;
      jog_d_r    <= 1'b0;
      ctrl_d_r   <= 1'b0;
      preset_d_r <= 1'b0;
      ierr_r     <= 1'b0;
    end else begin
      start_d_r  <= start_cond;
      jog_d_r    <= jog_cond;
      ctrl_d_r   <= ctrl_cond;
      preset_d_r <= preset_cond;
      ierr_r     <= ierr_nxt;
    end
  end

  assign instruction_error_flag = ierr_r;

  // pin synchronisers: value taken once stages two and three agree
  localparam int PW = 3 * NUM_CH;
  logic [PW-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_fd_r;
  logic [PW-1:0] pin_f_nxt, pin_rise;

  always_comb begin
    pin_f_nxt = pin_f_r;
    if (pin_s2_r == pin_s3_r) begin
      pin_f_nxt = pin_s3_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_f_r  <= '0;
      pin_fd_r <= '0;
    end else begin
      pin_s1_r <= {estop_pin, limit_hi_pin, limit_lo_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= pin_f_nxt;
      pin_fd_r <= pin_f_r;
    end
  end

  assign pin_rise = pin_f_r & ~pin_fd_r;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      tapp_state_t        state_r, state_nxt;
      logic [4:0]         step_r, step_nxt, nstep;
      logic signed [31:0] pos_r, pos_nxt;
      logic [32:0]        remain_r, remain_nxt, delta;
      logic               dir_r, dir_nxt;
      logic [16:0]        speed_r, speed_nxt;
      logic               stop_r, stop_nxt;
      logic [13:0]        dwell_r, dwell_nxt;
      logic [14:0]        cyc_r, cyc_nxt;
      logic               err_r, err_nxt, proh_r, proh_nxt;
      logic [ENTRY_W-1:0] ent;
      logic               tick, moving, trip;
      logic               st_hit, jog_hit, ctl_hit, pre_hit;
      logic               wr_hit;

      assign wr_hit  = tbl_wr_en && (tbl_wr_ch == 8'(c));
      assign st_hit  = start_rise && !start_bad && (start_ch == 8'(c));
      assign jog_hit = jog_rise && !jog_bad && (jog_ch == 8'(c));
      assign ctl_hit = ctrl_rise && !ctrl_bad && (ctrl_ch == 8'(c));
      assign pre_hit = preset_rise && !preset_bad && (preset_ch == 8'(c));
      assign moving  = (state_r == TAPP_MOVE) || (state_r == TAPP_JOG);
      assign trip    = pin_rise[c] || pin_rise[NUM_CH + c] ||
                       pin_rise[2*NUM_CH + c];

      tapp_step_mem #(.WIDTH(ENTRY_W), .DEPTH(21)) u_mem (
        .clock   (clock),
        .wr_en   (wr_hit),
        .wr_idx  (tbl_wr_step),
        .wr_data ({tbl_wr_repeat, tbl_wr_mode, tbl_wr_abs, tbl_wr_next,
                   tbl_wr_dwell, tbl_wr_speed, tbl_wr_addr}),
        .rd_idx  (step_r),
        .rd_data (ent)
      );

      tapp_pulse_gen #(.HZ(CLK_HZ)) u_pgen (
        .clock (clock),
        .rstn  (rstn),
        .run   (moving),
        .speed (speed_r),
        .tick  (tick)
      );

      always_comb begin
        state_nxt  = state_r;
        step_nxt   = step_r;
        pos_nxt    = pos_r;
        remain_nxt = remain_r;
        dir_nxt    = dir_r;
        speed_nxt  = speed_r;
        stop_nxt   = stop_r;
        dwell_nxt  = dwell_r;
        cyc_nxt    = cyc_r;
        err_nxt    = err_r;
        proh_nxt   = proh_r;
        nstep = (ent[F_NEXT +: 5] == STEP_AUTO) ? step_r + 5'h01
                                                : ent[F_NEXT +: 5];
        if (ent[F_ABS]) begin
          delta = {ent[F_ADDR+31], ent[F_ADDR +: 32]} -
                  {pos_r[31], pos_r};
        end else begin
          delta = {ent[F_ADDR+31], ent[F_ADDR +: 32]};
        end
        if (moving && tick) begin
          pos_nxt = dir_r ? pos_r - 32'sd1 : pos_r + 32'sd1;
        end
        if (pre_hit && !moving) begin
          pos_nxt = preset_value_operand;
        end
        // decelerating stop: drop speed once per ms, halt at the floor
        if (stop_r && moving) begin
          cyc_nxt = (cyc_r == MS_LAST) ? '0 : cyc_r + 15'h0001;
          if (cyc_r == MS_LAST) begin
            if (speed_r > SPEED_MIN + RAMP_PPS) begin
              speed_nxt = speed_r - RAMP_PPS;
            end else begin
              state_nxt = TAPP_IDLE;
            end
          end
        end
        // error reset first, so a fault in the same cycle still latches
        if (ctl_hit && ctrl_code == CTRL_ERRRST) begin
          err_nxt  = 1'b0;
          proh_nxt = 1'b0;
        end
        case (state_r)
          TAPP_IDLE: begin
            stop_nxt = 1'b0;
            if (st_hit && !proh_r) begin
              step_nxt  = start_step[4:0];
              state_nxt = TAPP_FETCH;
            end else if (jog_hit) begin
              dir_nxt   = first_numeric_operand;
              speed_nxt = second_numeric_operand ? JOG_HI : JOG_LO;
              cyc_nxt   = '0;
              state_nxt = TAPP_JOG;
            end
          end
          TAPP_FETCH: begin
            state_nxt = TAPP_LOAD;
          end
          TAPP_LOAD: begin
            speed_nxt = ent[F_SPEED +: 17];
            dir_nxt   = delta[32];
            remain_nxt = delta[32] ? 33'h0 - delta : delta;
            cyc_nxt   = '0;
            if (ent[F_SPEED +: 17] < SPEED_MIN ||
                ent[F_SPEED +: 17] > SPEED_MAX) begin
              err_nxt   = 1'b1;
              state_nxt = TAPP_IDLE;
            end else if (remain_nxt == 33'h0) begin
              dwell_nxt = ent[F_DWELL +: 14];
              state_nxt = TAPP_DWELL;
            end else begin
              state_nxt = TAPP_MOVE;
            end
          end
          TAPP_MOVE: begin
            if (!stop_r) begin
              speed_nxt = ent[F_SPEED +: 17];
            end
            if (tick) begin
              remain_nxt = remain_r - 33'h1;
              if (remain_r == 33'h1) begin
                dwell_nxt = (ent[F_DWELL +: 14] > DWELL_MAX) ?
                            DWELL_MAX : ent[F_DWELL +: 14];
                cyc_nxt   = '0;
                state_nxt = stop_r ? TAPP_IDLE : TAPP_DWELL;
              end
            end
          end
          TAPP_DWELL: begin
            if (stop_r) begin
              state_nxt = TAPP_IDLE;
            end else if (dwell_r != 14'h0) begin
              cyc_nxt = (cyc_r == MS_LAST) ? '0 : cyc_r + 15'h0001;
              if (cyc_r == MS_LAST) begin
                dwell_nxt = dwell_r - 14'h0001;
              end
            end else if (ent[F_MODE +: 2] == MODE_END) begin
              state_nxt = TAPP_IDLE;
            end else if (nstep > STEP_LAST || nstep == STEP_AUTO) begin
              if (ent[F_REPEAT]) begin
                step_nxt  = STEP_FIRST;
                state_nxt = TAPP_FETCH;
              end else begin
                state_nxt = TAPP_IDLE;
              end
            end else begin
              step_nxt  = nstep;
              state_nxt = TAPP_FETCH;
            end
          end
          TAPP_JOG: begin
            if (!stop_r) begin
              speed_nxt = second_numeric_operand ? JOG_HI : JOG_LO;
            end
            if (!jog_cond) begin
              state_nxt = TAPP_IDLE;
            end
          end
          default: begin
            state_nxt = TAPP_IDLE;
          end
        endcase
        if (ctl_hit) begin
          if (ctrl_code == CTRL_DECEL && state_r != TAPP_IDLE) begin
            stop_nxt = 1'b1;
            cyc_nxt  = '0;
          end else if (ctrl_code == CTRL_ESTOP) begin
            state_nxt = TAPP_IDLE;
          end
        end
        // detection after the reset so that a same-cycle event wins
        if (trip && state_r != TAPP_IDLE) begin
          state_nxt = TAPP_IDLE;
          err_nxt   = 1'b1;
          proh_nxt  = 1'b1;
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          state_r  <= TAPP_IDLE;
          step_r   <= STEP_FIRST;
          pos_r    <= '0;
          remain_r <= '0;
          dir_r    <= 1'b0;
          speed_r  <= '0;
          stop_r   <= 1'b0;
          dwell_r  <= '0;
          cyc_r    <= '0;
          err_r    <= 1'b0;
          proh_r   <= 1'b0;
        end else begin
          state_r  <= state_nxt;
          step_r   <= step_nxt;
          pos_r    <= pos_nxt;
          remain_r <= remain_nxt;
          dir_r    <= dir_nxt;
          speed_r  <= speed_nxt;
          stop_r   <= stop_nxt;
          dwell_r  <= dwell_nxt;
          cyc_r    <= cyc_nxt;
          err_r    <= err_nxt;
          proh_r   <= proh_nxt;
        end
      end

      // a running channel ignores new start and jog requests (IDLE only)
      assign pulse_out[c]       = tick;
      assign dir_rev_out[c]     = dir_r;
      assign busy[c]            = state_r != TAPP_IDLE;
      assign error_latched[c]   = err_r;
      assign output_prohibit[c] = proh_r;
      assign step_now[c]        = step_r;
      assign cur_pos[c]         = pos_r;
    end
  endgenerate

endmodule : tapp_positioner

// File: sim/tapp_positioner_assertions.sv
// concurrent checks on the positioner's command and status ports
`timescale 1ns/1ps
module tapp_positioner_assertions
  import tapp_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic                   start_cond,
  input wire logic [7:0]             start_ch,
  input wire logic [7:0]             start_step,
  input wire logic                   jog_cond,
  input wire logic [7:0]             jog_ch,
  input wire logic                   ctrl_cond,
  input wire logic [7:0]             ctrl_ch,
  input wire logic [7:0]             ctrl_code,
  input wire logic                   preset_cond,
  input wire logic [NUM_CH-1:0]      limit_lo_pin,
  input wire logic [NUM_CH-1:0]      limit_hi_pin,
  input wire logic [NUM_CH-1:0]      estop_pin,
  input wire logic [NUM_CH-1:0]      busy,
  input wire logic [NUM_CH-1:0]      error_latched,
  input wire logic [NUM_CH-1:0]      output_prohibit,
  input wire logic [NUM_CH-1:0][4:0] step_now,
  input wire logic                   instruction_error_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // previous condition levels, cleared by reset like the design's own
  logic st_d_r;
  logic jg_d_r;
  logic ct_d_r;
  logic pr_d_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_d_r <= 1'b0;
      jg_d_r <= 1'b0;
      ct_d_r <= 1'b0;
      pr_d_r <= 1'b0;
    end else begin
      st_d_r <= start_cond;
      jg_d_r <= jog_cond;
      ct_d_r <= ctrl_cond;
      pr_d_r <= preset_cond;
    end
  end
  wire st_rise = start_cond & ~st_d_r;
  wire jg_rise = jog_cond & ~jg_d_r;
  wire ct_rise = ctrl_cond & ~ct_d_r;
  wire any_rise = st_rise | jg_rise | ct_rise | (preset_cond & ~pr_d_r);
  wire pins0 = limit_lo_pin[0] | limit_hi_pin[0] | estop_pin[0];

  sequence s_start0;
    st_rise && start_ch == 8'h00 && start_step != 8'h00 &&
    start_step <= 8'h14 && !busy[0] && !output_prohibit[0] &&
    !(jg_rise && jog_ch == 8'h00) && !ct_rise;
  endsequence
  sequence s_trip0;
    busy[0] && estop_pin[0] && !$past(estop_pin[0]);
  endsequence

  AST_START_RUNS: assert property (
    s_start0 |=> busy[0] && step_now[0] == $past(start_step[4:0]))
    else $error("start did not begin at the given step");
  AST_BAD_START_CH: assert property (
    st_rise && start_ch > 8'h01 && !jg_rise && !ct_rise
    |=> instruction_error_flag && busy == $past(busy))
    else $error("bad start channel not refused");
  AST_BAD_STEP: assert property (
    st_rise && (start_step == 8'h00 || start_step > 8'h14)
    |=> instruction_error_flag)
    else $error("bad step number not flagged");
  AST_BAD_JOG_CH: assert property (
    jg_rise && jog_ch > 8'h01 |=> instruction_error_flag)
    else $error("bad jog channel not flagged");
  AST_BAD_CODE: assert property (
    ct_rise && ctrl_code > CTRL_ERRRST |=> instruction_error_flag)
    else $error("bad control code not flagged");
  AST_FLAG_CAUSE: assert property (
    instruction_error_flag |-> $past(any_rise))
    else $error("error flag without a command edge");
  AST_ESTOP_CODE: assert property (
    ct_rise && ctrl_ch == 8'h00 && ctrl_code == CTRL_ESTOP
    |=> !busy[0] [*2])
    else $error("emergency stop did not halt at once");
  AST_ERR_RESET: assert property (
    ct_rise && ctrl_ch == 8'h00 && ctrl_code == CTRL_ERRRST && !pins0
    |=> !error_latched[0] && !output_prohibit[0])
    else $error("error reset did not clear the latches");
  AST_TRIP: assert property (
    s_trip0 |-> ##[1:8] (error_latched[0] && output_prohibit[0] && !busy[0]))
    else $error("emergency input did not stop and prohibit");
endmodule : tapp_positioner_assertions

// File: sim/tapp_drive_model.sv
// behavioural motor drive: counts pulses, reports limits and emergency
`timescale 1ns/1ps
module tapp_drive_model
  import tapp_pkg::*;
#(
  parameter int LIM = 4000
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic [NUM_CH-1:0]       pulse_out,
  input  wire logic [NUM_CH-1:0]       dir_rev_out,
  input  wire logic [NUM_CH-1:0]       trip,
  output logic      [NUM_CH-1:0]       limit_lo_pin,
  output logic      [NUM_CH-1:0]       limit_hi_pin,
  output logic      [NUM_CH-1:0]       estop_pin,
  output logic      [NUM_CH-1:0][31:0] pos,
  output logic      [31:0]             pulses
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pos <= '0;
      pulses <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (pulse_out[c]) begin
          pos[c] <= dir_rev_out[c] ? pos[c] - 32'h1 : pos[c] + 32'h1;
        end
      end
      if (pulse_out[0]) begin
        pulses <= pulses + 32'h1;
      end
    end
  end
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      limit_hi_pin[c] = $signed(pos[c]) > LIM;
      limit_lo_pin[c] = $signed(pos[c]) < -LIM;
    end
  end
  assign estop_pin = trip;
endmodule : tapp_drive_model

// File: sim/tb_top.sv
// self-checking bench for the two-axis pulse positioner
`timescale 1ns/1ps
module tb_top;
  import tapp_pkg::*;
  logic clock, rstn, tbl_wr_en, tbl_wr_abs, tbl_wr_repeat, start_cond;
  logic jog_cond, first_numeric_operand, second_numeric_operand, ctrl_cond;
  logic preset_cond, instruction_error_flag, flag_seen;
  logic [7:0] tbl_wr_ch, start_ch, start_step, jog_ch, ctrl_ch, ctrl_code;
  logic [7:0] preset_ch;
  logic [4:0] tbl_wr_step, tbl_wr_next;
  logic [31:0] tbl_wr_addr, preset_value_operand, pulses;
  logic [16:0] tbl_wr_speed;
  logic [13:0] tbl_wr_dwell;
  logic [1:0] tbl_wr_mode;
  logic [NUM_CH-1:0] limit_lo_pin, limit_hi_pin, estop_pin, trip, pulse_out;
  logic [NUM_CH-1:0] dir_rev_out, busy, error_latched, output_prohibit;
  logic [NUM_CH-1:0][4:0] step_now;
  logic [NUM_CH-1:0][31:0] cur_pos, pos;
  int failures, num_checks, lo_n, hi_n;

  tapp_positioner #(.MS_CYCLES(10), .JOG_LO(17'h0c350), .JOG_HI(17'h186a0))
  i_dut (.clock, .rstn, .tbl_wr_en, .tbl_wr_ch, .tbl_wr_step, .tbl_wr_addr,
    .tbl_wr_speed, .tbl_wr_dwell, .tbl_wr_next, .tbl_wr_abs, .tbl_wr_mode,
    .tbl_wr_repeat, .start_cond, .start_ch, .start_step, .jog_cond, .jog_ch,
    .first_numeric_operand, .second_numeric_operand, .ctrl_cond, .ctrl_ch,
    .ctrl_code, .preset_cond, .preset_ch, .preset_value_operand,
    .limit_lo_pin, .limit_hi_pin, .estop_pin, .pulse_out, .dir_rev_out,
    .busy, .error_latched, .output_prohibit, .step_now, .cur_pos,
    .instruction_error_flag);
  tapp_drive_model i_drv (.clock, .rstn, .pulse_out, .dir_rev_out, .trip,
    .limit_lo_pin, .limit_hi_pin, .estop_pin, .pos, .pulses);

  initial clock = 1'b0;
  always #20 clock = ~clock;

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task results;
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task wait_idle(input int ch);
    int n;
    n = 0;
    while (busy[ch] !== 1'b0 && n < 6000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 6000) begin
      failures++;
      results();
    end
  endtask : wait_idle
  // raise one command condition for a cycle; jog stays up until lowered
  task cmd(input int k);
    @(negedge clock);
    case (k)
      0: start_cond = 1'b1;
      1: ctrl_cond = 1'b1;
      2: preset_cond = 1'b1;
      default: jog_cond = 1'b1;
    endcase
    @(negedge clock);
    flag_seen = instruction_error_flag;
    start_cond = 1'b0;
    ctrl_cond = 1'b0;
    preset_cond = 1'b0;
    @(negedge clock);
    flag_seen = flag_seen | instruction_error_flag;
  endtask : cmd
  task wr(input logic [4:0] st, input logic [31:0] ad, input logic abs_m,
          input logic [13:0] dw, input logic [1:0] md);
    @(negedge clock);
    {tbl_wr_step, tbl_wr_addr, tbl_wr_abs, tbl_wr_dwell} = {st, ad, abs_m, dw};
    {tbl_wr_mode, tbl_wr_speed, tbl_wr_en} = {md, SPEED_MAX, 1'b1};
    @(negedge clock);
    tbl_wr_en = 1'b0;
  endtask : wr
  task bad(input int k);
    cmd(k);
    chk("error flag", flag_seen, 1);
    chk("busy", busy, 0);
  endtask : bad

  task t_bad;
    {start_ch, start_step} = {8'h02, 8'h01};
    bad(0);
    {start_ch, start_step} = {8'h00, 8'h00};
    bad(0);
    start_step = 8'h15;
    bad(0);
    jog_ch = 8'h05;
    bad(3);
    jog_cond = 1'b0;
    {ctrl_ch, ctrl_code} = {8'h00, 8'h03};
    bad(1);
    {ctrl_ch, ctrl_code} = {8'h02, CTRL_DECEL};
    bad(1);
  endtask : t_bad
  task t_move;
    {preset_ch, preset_value_operand} = {8'h00, 32'd100};
    cmd(2);
    chk("cur_pos0", cur_pos[0], 32'd100);
    wr(5'h01, 32'd103, 1'b1, 14'h0002, MODE_CONT);
    wr(5'h02, -32'sd2, 1'b0, 14'h0000, MODE_END);
    {start_ch, start_step} = {8'h00, 8'h01};
    cmd(0);
    chk("busy0", busy[0], 1);
    wait_idle(0);
    chk("cur_pos0", cur_pos[0], 32'd101);
    chk("drive pos0", pos[0], 32'd1);
    chk("pulses0", pulses, 32'd5);
    chk("dir0", dir_rev_out[0], 1);
    chk("error0", error_latched[0], 0);
  endtask : t_move
  task t_jog;
    {jog_ch, first_numeric_operand, second_numeric_operand} = 10'h006;
    cmd(3);
    lo_n = 0;
    hi_n = 0;
    repeat (3000) begin
      @(negedge clock);
      if (pulse_out[1] === 1'b1) lo_n++;
    end
    {first_numeric_operand, second_numeric_operand} = 2'b01;
    repeat (3000) begin
      @(negedge clock);
      if (pulse_out[1] === 1'b1) hi_n++;
    end
    chk("jog dir1", dir_rev_out[1], 1);
    chk("jog faster", hi_n > lo_n, 1);
    {start_ch, start_step} = {8'h01, 8'h05};
    cmd(0);
    chk("step_now1", step_now[1], 5'h01);
    chk("busy1", busy[1], 1);
    jog_cond = 1'b0;
    wait_idle(1);
    chk("drive pos1 sign", pos[1][31], 1);
  endtask : t_jog
  task t_stop;
    wr(5'h03, 32'd1000, 1'b0, 14'h0000, MODE_END);
    {start_ch, start_step, ctrl_ch, ctrl_code} = {24'h000300, CTRL_ESTOP};
    cmd(0);
    repeat (600) @(negedge clock);
    cmd(1);
    chk("busy0 estop", busy[0], 0);
    cmd(0);
    repeat (600) @(negedge clock);
    trip[0] = 1'b1;
    repeat (10) @(negedge clock);
    chk("error0", error_latched[0], 1);
    chk("prohibit0", output_prohibit[0], 1);
    cmd(0);
    chk("busy0 refused", busy[0], 0);
    trip[0] = 1'b0;
    ctrl_code = CTRL_ERRRST;
    cmd(1);
    chk("error0 reset", error_latched[0], 0);
    chk("prohibit0 reset", output_prohibit[0], 0);
    cmd(0);
    repeat (600) @(negedge clock);
    ctrl_code = CTRL_DECEL;
    cmd(1);
    chk("busy0 ramp", busy[0], 1);
    wait_idle(0);
  endtask : t_stop

  initial begin
    {rstn, tbl_wr_en, tbl_wr_abs, tbl_wr_repeat, start_cond, jog_cond} = '0;
    {first_numeric_operand, second_numeric_operand, ctrl_cond} = '0;
    {preset_cond, tbl_wr_ch, start_ch, start_step, jog_ch} = '0;
    {ctrl_ch, ctrl_code, preset_ch, tbl_wr_step, tbl_wr_next} = '0;
    {tbl_wr_addr, preset_value_operand, tbl_wr_speed} = '0;
    {tbl_wr_dwell, tbl_wr_mode, trip, failures, num_checks} = '0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    chk("busy", busy, 0);
    chk("step_now0", step_now[0], 5'h01);
    chk("prohibit", output_prohibit, 0);
    t_bad();
    t_move();
    t_jog();
    t_stop();
    results();
  end
endmodule : tb_top

bind tapp_positioner tapp_positioner_assertions i_chk (.clock, .rstn,
  .start_cond, .start_ch, .start_step, .jog_cond, .jog_ch, .ctrl_cond,
  .ctrl_ch, .ctrl_code, .preset_cond, .limit_lo_pin, .limit_hi_pin,
  .estop_pin, .busy, .error_latched, .output_prohibit, .step_now,
  .instruction_error_flag);
